/* translate_pkg.sv */
// shared constants and types for the byte string translate unit
package translate_pkg;
   // register byte offsets on the wishbone slave
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] INSN_OFS = 8'h04;
   localparam logic [7:0] PTR_OFS = 8'h08;
   localparam logic [7:0] TABLE_OFS = 8'h0c;
   localparam logic [7:0] COUNT_OFS = 8'h10;
   localparam logic [7:0] FLAGS_OFS = 8'h14;
   localparam logic [7:0] STATUS_OFS = 8'h18;
   localparam logic [7:0] RESULT_OFS = 8'h1c;

   // control register fields
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;

   // status register fields
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_ILLEGAL_BIT = 2;
   localparam int STAT_SUSPEND_BIT = 3;

   // flag positions inside the six bit flag register
   localparam int FLAG_C = 5;
   localparam int FLAG_Z = 4;
   localparam int FLAG_S = 3;
   localparam int FLAG_V = 2;
   localparam int FLAG_D = 1;
   localparam int FLAG_H = 0;

   // reset values
   localparam logic [31:0] PTR_RST = 32'h0000_0000;
   localparam logic [31:0] TABLE_RST = 32'h0000_0000;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [31:0] INSN_RST = 32'h0000_0000;
   localparam logic [5:0] FLAGS_RST = 6'h00;
   localparam logic [7:0] RESULT_RST = 8'h00;

   // instruction encoding
   localparam logic [7:0] OPC_HIGH = 8'hb8;
   localparam logic [3:0] VAR_INC = 4'h0;
   localparam logic [3:0] VAR_INC_REP = 4'h4;
   localparam logic [3:0] VAR_DEC_REP = 4'hc;
   localparam logic [3:0] VAR_TEST_DEC = 4'ha;
   localparam logic [3:0] FIELD_ZERO = 4'h0;

   // address representation modes
   typedef enum logic [1:0] {
      MODE_COMPACT = 2'h0,
      MODE_SEGMENTED = 2'h1,
      MODE_LINEAR = 2'h2
   } addr_mode_t;

   // decoded instruction variants
   typedef enum logic [1:0] {
      translate_increment_op,
      translate_increment_repeat_op,
      translate_decrement_repeat_op,
      translate_test_decrement_op
   } variant_t;
endpackage

/* mode_address_add.sv */
// address adder following the compact, segmented or linear arithmetic
`timescale 1ns/10ps
module mode_address_add
(
   // operands
   input wire logic [31:0] base_i,
   input wire logic [31:0] delta_i,
   input wire translate_pkg::addr_mode_t mode_i,
   // result
   output logic [31:0] sum_o
);
   import translate_pkg::*;

   logic [15:0] low_sum;

   // segmented keeps the segment half, compact has no upper half at all
   always_comb
   begin
      low_sum = base_i[15:0] + delta_i[15:0];
      unique case (mode_i)
         MODE_COMPACT: sum_o = {16'h0000, low_sum};
         MODE_SEGMENTED: sum_o = {base_i[31:16], low_sum};
         MODE_LINEAR: sum_o = base_i + delta_i;
         default: sum_o = base_i + delta_i; // unused mode code acts linear
      endcase
   end
endmodule // mode_address_add

/* byte_string_translate_unit.sv */
// byte string translate execution unit with wishbone register access
//
// Behaviour
// - fetch target byte, add zero-extended to table
// - replacing variants write looked-up byte back
// - increment variants step pointer up one
// - replacing decrement variant steps pointer down
// - counter decremented in the same cycle as every pointer update
// - table base register never changed by translate
// - repeat until decremented counter reaches zero
// - zero counter runs 65,536 iterations
// - interrupts accepted between repeated steps
// - repeat completion sets V, others kept
// - single step V reflects counter zero
// - test variant loads result byte, memory untouched
// - test variant Z set on zero byte
// - test decrement steps first source down
// - table spans up to 256 byte entries
// - pointers word-wide compact, longword otherwise
// - decode two-word encoding, reject others
`timescale 1ns/10ps
module byte_string_translate_unit
(
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // processor memory port, one byte per access
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [31:0] mem_addr_o,
   output logic [7:0] mem_wdata_o,
   input wire logic [7:0] mem_rdata_i,
   input wire logic mem_ack_i,
   // core interrupt hand-off
   input wire logic int_pending_i,
   output logic busy_o,
   output logic done_o,
   output logic suspended_o
);
   import translate_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_READ_TARGET,
      ST_READ_TABLE,
      ST_WRITE_BACK,
      ST_UPDATE
   } fsm_t;

   typedef struct packed {
      fsm_t fsm;
      variant_t op;
      addr_mode_t mode;
      logic [31:0] insn;
      logic [31:0] ptr;
      logic [31:0] tbl;
      logic [15:0] cnt;
      logic [5:0] flags;
      logic [7:0] result;
      logic [7:0] xlat;
      logic busy;
      logic done;
      logic illegal;
      logic suspended;
      logic ack;
      logic [31:0] rdata;
      logic mem_req;
      logic mem_we;
      logic [31:0] mem_addr;
      logic [7:0] mem_wdata;
   } state_t;

   localparam state_t RESET_S = '{
      fsm: ST_IDLE,
      op: translate_increment_op,
      mode: MODE_COMPACT,
      insn: INSN_RST,
      ptr: PTR_RST,
      tbl: TABLE_RST,
      cnt: COUNT_RST,
      flags: FLAGS_RST,
      result: RESULT_RST,
      xlat: 8'h00,
      busy: 1'b0,
      done: 1'b0,
      illegal: 1'b0,
      suspended: 1'b0,
      ack: 1'b0,
      rdata: 32'h0000_0000,
      mem_req: 1'b0,
      mem_we: 1'b0,
      mem_addr: 32'h0000_0000,
      mem_wdata: 8'h00
   };

   state_t s;
   state_t next_s;
   logic [31:0] lookup_addr;
   logic [31:0] ptr_step;
   logic [31:0] ptr_delta;
   logic [31:0] ptr_addr;
   logic [15:0] cnt_dec;
   logic step_down;
   logic is_repeat;
   logic is_test;
   logic wb_req;
   logic insn_legal;
   variant_t insn_op;

   // merge written bytes under the wishbone byte selects
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

   // compact pointers are word registers, upper half reads as zero
   function automatic logic [31:0] fit(input logic [31:0] v, input addr_mode_t m);
      return (m == MODE_COMPACT) ? {16'h0000, v[15:0]} : v;
   endfunction

   // opcode check covers both words of the encoding
   always_comb
   begin
      insn_legal = (s.insn[31:24] == OPC_HIGH) && (s.insn[23:20] != FIELD_ZERO)
         && (s.insn[15:12] == FIELD_ZERO) && (s.insn[7:4] != FIELD_ZERO)
         && (s.insn[3:0] == FIELD_ZERO);
      insn_op = translate_increment_op;
      unique case (s.insn[19:16])
         VAR_INC: insn_op = translate_increment_op;
         VAR_INC_REP: insn_op = translate_increment_repeat_op;
         VAR_DEC_REP: insn_op = translate_decrement_repeat_op;
         VAR_TEST_DEC: insn_op = translate_test_decrement_op;
         default: insn_legal = 1'b0;
      endcase
   end

   // variant properties
   assign step_down = (s.op == translate_decrement_repeat_op)
      || (s.op == translate_test_decrement_op);
   assign is_repeat = (s.op == translate_increment_repeat_op)
      || (s.op == translate_decrement_repeat_op);
   assign is_test = (s.op == translate_test_decrement_op);
   assign ptr_delta = step_down ? 32'hffff_ffff : 32'h0000_0001;
   assign ptr_addr = fit(s.ptr, s.mode);
   assign cnt_dec = s.cnt - 16'h0001; // 0 wraps to ffff
   assign wb_req = cyc_i && stb_i && !s.ack;

   // table index is the target byte zero-extended, so 256 entries at most
   mode_address_add lookup_add (
      .base_i(s.tbl),
      .delta_i({24'h000000, s.xlat}),
      .mode_i(s.mode),
      .sum_o(lookup_addr)
   );

   // pointer step in the current address arithmetic
   mode_address_add pointer_add (
      .base_i(s.ptr),
      .delta_i(ptr_delta),
      .mode_i(s.mode),
      .sum_o(ptr_step)
   );

   // register bus and execution sequencing
   always_comb
   begin
      next_s = s;
      next_s.done = 1'b0;
      next_s.ack = wb_req;

      // read side answers one cycle after the request, unmapped reads zero
      next_s.rdata = 32'h0000_0000;
      if (wb_req && !we_i)
      begin
         unique case (adr_i)
            CTRL_OFS: next_s.rdata = {29'h0, s.mode, 1'b0};
            INSN_OFS: next_s.rdata = s.insn;
            PTR_OFS: next_s.rdata = fit(s.ptr, s.mode);
            TABLE_OFS: next_s.rdata = fit(s.tbl, s.mode);
            COUNT_OFS: next_s.rdata = {16'h0000, s.cnt};
            FLAGS_OFS: next_s.rdata = {26'h0, s.flags};
            STATUS_OFS: next_s.rdata = {28'h0, s.suspended, s.illegal, s.done, s.busy};
            RESULT_OFS: next_s.rdata = {24'h000000, s.result};
            default: next_s.rdata = 32'h0000_0000;
         endcase
      end

      // writes to operands are ignored while an instruction runs
      if (wb_req && we_i && !s.busy)
      begin
         unique case (adr_i)
            CTRL_OFS:
            begin
               if (sel_i[0])
               begin
                  next_s.mode = addr_mode_t'(dat_i[CTRL_MODE_LSB +: 2]);
                  if (dat_i[CTRL_START_BIT])
                  begin
                     next_s.illegal = !insn_legal;
                     next_s.suspended = 1'b0;
                     if (insn_legal)
                     begin
                        next_s.op = insn_op;
                        next_s.busy = 1'b1;
                        next_s.fsm = ST_READ_TARGET;
                        next_s.mem_req = 1'b1;
                        next_s.mem_we = 1'b0;
                        next_s.mem_addr = fit(s.ptr, next_s.mode);
                     end
                  end
               end
            end
            INSN_OFS: next_s.insn = merge(s.insn, dat_i, sel_i);
            PTR_OFS: next_s.ptr = merge(s.ptr, dat_i, sel_i);
            TABLE_OFS: next_s.tbl = merge(s.tbl, dat_i, sel_i);
            COUNT_OFS: next_s.cnt = 16'(merge({16'h0000, s.cnt}, dat_i, sel_i));
            FLAGS_OFS: next_s.flags = 6'(merge({26'h0, s.flags}, dat_i, sel_i));
            RESULT_OFS: next_s.result = 8'(merge({24'h0, s.result}, dat_i, sel_i));
            default: next_s.ack = wb_req; // unmapped writes are acked and dropped
         endcase
      end

      // one basic step: read target, read table, write back except for the test form, then update
      unique case (s.fsm)
         ST_IDLE:
         begin
         end
         ST_READ_TARGET:
         begin
            if (s.mem_req && mem_ack_i)
            begin
               next_s.xlat = mem_rdata_i;
               next_s.fsm = ST_READ_TABLE;
               next_s.mem_req = 1'b0;
            end
            else if (!s.mem_req)
            begin
               next_s.mem_req = 1'b1;
               next_s.mem_we = 1'b0;
               next_s.mem_addr = ptr_addr;
            end
         end
         ST_READ_TABLE:
         begin
            if (!s.mem_req)
            begin
               next_s.mem_req = 1'b1;
               next_s.mem_we = 1'b0;
               next_s.mem_addr = lookup_addr;
            end
            else if (mem_ack_i)
            begin
               next_s.mem_req = 1'b0;
               next_s.xlat = mem_rdata_i;
               if (is_test)
               begin
                  next_s.result = mem_rdata_i;
                  next_s.flags[FLAG_Z] = (mem_rdata_i == 8'h00);
                  next_s.fsm = ST_UPDATE; // no write for the test form
               end
               else
               begin
                  next_s.fsm = ST_WRITE_BACK;
               end
            end
         end
         ST_WRITE_BACK:
         begin
            if (!s.mem_req)
            begin
               next_s.mem_req = 1'b1;
               next_s.mem_we = 1'b1;
               next_s.mem_addr = ptr_addr;
               next_s.mem_wdata = s.xlat;
            end
            else if (mem_ack_i)
            begin
               next_s.mem_req = 1'b0;
               next_s.mem_we = 1'b0;
               next_s.fsm = ST_UPDATE;
            end
         end
         ST_UPDATE:
         begin
            // table base is left alone on purpose
            next_s.ptr = ptr_step;
            next_s.cnt = cnt_dec;
            if (!is_repeat)
            begin
               next_s.flags[FLAG_V] = (cnt_dec == 16'h0000);
               next_s.fsm = ST_IDLE;
               next_s.busy = 1'b0;
               next_s.done = 1'b1;
            end
            else if (cnt_dec == 16'h0000)
            begin
               next_s.flags[FLAG_V] = 1'b1;
               next_s.fsm = ST_IDLE;
               next_s.busy = 1'b0;
               next_s.done = 1'b1;
            end
            else if (int_pending_i)
            begin
               // registers already advanced, so a restart carries on
               next_s.fsm = ST_IDLE;
               next_s.busy = 1'b0;
               next_s.suspended = 1'b1;
            end
            else
            begin
               next_s.fsm = ST_READ_TARGET;
               next_s.mem_req = 1'b1;
               next_s.mem_we = 1'b0;
               next_s.mem_addr = fit(ptr_step, s.mode);
            end
         end
      endcase
   end

   // single state register, frozen while the enable is low
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s <= RESET_S;
      end
      else if (ce_i)
      begin
         s <= next_s;
      end
   end

   // all outputs come straight from the state register
   assign dat_o = s.rdata;
   assign ack_o = s.ack;
   assign mem_req_o = s.mem_req;
   assign mem_we_o = s.mem_we;
   assign mem_addr_o = s.mem_addr;
   assign mem_wdata_o = s.mem_wdata;
   assign busy_o = s.busy;
   assign done_o = s.done;
   assign suspended_o = s.suspended;
endmodule // byte_string_translate_unit

/* translate_unit_properties.sv */
// concurrent checks on the ports of the byte string translate unit
`timescale 1ns/10ps
module translate_unit_properties
(
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // register bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // memory port
   input wire logic mem_req_o,
   input wire logic mem_we_o,
   input wire logic [31:0] mem_addr_o,
   input wire logic [7:0] mem_wdata_o,
   input wire logic [7:0] mem_rdata_i,
   input wire logic mem_ack_i,
   // core hand-off
   input wire logic int_pending_i,
   input wire logic busy_o,
   input wire logic done_o,
   input wire logic suspended_o
);
   logic [31:0] rd_prev;
   logic [31:0] rd_last;
   logic [7:0] tab_byte;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // two latest read addresses; the older one is the target byte of a step
   always_ff @(posedge clk_i)
   begin
      if (mem_req_o && mem_ack_i && !mem_we_o)
      begin
         rd_prev <= rd_last;
         rd_last <= mem_addr_o;
         tab_byte <= mem_rdata_i;
      end
   end

   a_ack_after_req: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o)
      else $error("bus request not answered in the next cycle");
   a_ack_one_pulse: assert property (ack_o && ce_i |=> !ack_o)
      else $error("bus acknowledge longer than one cycle");
   a_mem_req_held: assert property (mem_req_o && !mem_ack_i |=>
      mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
      else $error("memory request changed before its answer");
   a_mem_req_drop: assert property (mem_req_o && mem_ack_i && ce_i |=>
      !mem_req_o)
      else $error("memory request kept after its answer");
   a_writeback_target: assert property (mem_req_o && mem_we_o |->
      mem_addr_o == rd_prev && mem_wdata_o == tab_byte)
      else $error("write-back address or byte wrong");
   a_done_clean: assert property (done_o |-> !mem_req_o ##1 !done_o)
      else $error("completion with access pending or stretched");
   a_suspend_idle: assert property (suspended_o |-> !busy_o && !mem_req_o)
      else $error("suspended unit still active");
   a_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
      !ack_o && !mem_req_o && !busy_o && !done_o)
      else $error("outputs active after reset");

   c_done: cover property (done_o);
   c_suspend: cover property ($rose(suspended_o));
   c_writeback: cover property (mem_req_o && mem_we_o && mem_ack_i);
endmodule // translate_unit_properties

/* byte_memory_model.sv */
// memory partner holding string and table bytes for the translate unit
`timescale 1ns/10ps
module byte_memory_model
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // extra wait cycles before each answer
   input wire logic [1:0] delay_i,
   // access request from the unit
   input wire logic req_i,
   input wire logic we_i,
   input wire logic [31:0] addr_i,
   input wire logic [7:0] wdata_i,
   // answer
   output logic [7:0] rdata_o,
   output logic ack_o
);
   logic [7:0] m [0:65535];
   logic [1:0] waited;

   // answer after delay_i cycles; only 16 address bits are backed
   always @(posedge clk_i)
   begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o; // garbage outside the answer cycle
      if (rst_i)
      begin
         waited <= 2'h0;
         rdata_o <= 8'h5a;
      end
      else if (req_i && !ack_o && waited < delay_i)
         waited <= waited + 2'h1;
      else if (req_i && !ack_o)
      begin
         waited <= 2'h0;
         ack_o <= 1'b1;
         if (we_i)
            m[addr_i[15:0]] <= wdata_i;
         else
            rdata_o <= m[addr_i[15:0]];
      end
   end
endmodule // byte_memory_model

/* byte_string_translate_unit_tb.sv */
// self-checking bench for the byte string translate unit
`timescale 1ns/10ps
module byte_string_translate_unit_tb;
   import translate_pkg::*;
   logic clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, int_pending_i;
   logic ack_o, mem_req_o, mem_we_o, mem_ack_i, busy_o, done_o, suspended_o;
   logic [7:0] adr_i, mem_wdata_o, mem_rdata_i, xres;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o, mem_addr_o, q, seed;
   logic [7:0] ref_m [0:65535];
   logic [3:0] vt [4];
   logic [1:0] dly, md;
   logic [5:0] xf;
   logic [15:0] xp, xc;
   int fail_count, checked;

   byte_string_translate_unit uut (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i,
      .sel_i, .dat_i, .dat_o, .ack_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o,
      .mem_rdata_i, .mem_ack_i, .int_pending_i, .busy_o, .done_o, .suspended_o);
   byte_memory_model mem (.clk_i, .rst_i, .delay_i(dly), .req_i(mem_req_o), .we_i(mem_we_o),
      .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));

   // free running clock
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // one classic cycle; released only at the edge that samples ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do
      begin
         @(posedge clk_i);
         k++;
      end
      while (ack_o !== 1'b1 && k < 64);
      chk(ack_o, 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask

   // load operands, start, wait, then replay the step in the reference model
   task automatic go(input logic [3:0] v, input logic ld, input logic [15:0] p,
                     input logic [15:0] c, input int lim);
      int k;
      logic rep;
      logic [7:0] b;
      rep = (v == VAR_INC_REP || v == VAR_DEC_REP);
      if (ld)
      begin
         xp = p;
         xc = c;
         xf = 6'(rnd());
         wb(1'b1, PTR_OFS, {16'h0, p});
         wb(1'b1, TABLE_OFS, 32'h1000);
         wb(1'b1, COUNT_OFS, {16'h0, c});
         wb(1'b1, FLAGS_OFS, {26'h0, xf});
      end
      dly <= 2'(rnd());
      md = 2'(rnd() % 3);
      wb(1'b1, INSN_OFS, {8'hb8, 4'h6, v, 4'h0, 4'hc, 4'h9, 4'h0});
      wb(1'b1, CTRL_OFS, {29'h0, md, 1'b1});
      // freeze while the first target read is pending, the step must resume intact
      if (v == VAR_DEC_REP && c > 16'h2)
      begin
         ce_i <= 1'b0;
         repeat (5) @(posedge clk_i);
         ce_i <= 1'b1;
      end
      if (ld && lim > 1 && c > 16'h2)
         wb(1'b1, TABLE_OFS, 32'h5555); // busy: must be dropped
      k = 0;
      do
      begin
         @(posedge clk_i);
         k++;
      end
      while (done_o !== 1'b1 && suspended_o !== 1'b1 && k < 4000);
      chk(k < 4000, 1'b1);
      k = 0;
      do
      begin
         b = ref_m[xp];
         b = ref_m[16'h1000 + {8'h0, b}];
         if (v == VAR_TEST_DEC)
            xres = b;
         else
            ref_m[xp] = b;
         xp = (v == VAR_INC || v == VAR_INC_REP) ? 16'(xp + 1) : 16'(xp - 1);
         xc = 16'(xc - 1);
         k++;
      end
      while (rep && xc != 0 && k < lim);
      chk(suspended_o, rep && xc != 0);
      // a suspended repeat leaves every flag as it was
      if (!rep || xc == 0)
         xf[FLAG_V] = (xc == 0);
      if (v == VAR_TEST_DEC)
         xf[FLAG_Z] = (xres == 8'h0);
      wb(1'b0, PTR_OFS, 32'h0);
      chk(q, 32'(xp));
      wb(1'b0, TABLE_OFS, 32'h0);
      chk(q, 32'h1000);
      wb(1'b0, COUNT_OFS, 32'h0);
      chk(q, 32'(xc));
      wb(1'b0, RESULT_OFS, 32'h0);
      chk(q, {24'h0, xres});
      wb(1'b0, FLAGS_OFS, 32'h0);
      chk(q, {26'h0, xf});
      wb(1'b0, CTRL_OFS, 32'h0);
      chk(q, {29'h0, md, 1'b0});
      for (int i = 'h3f00; i < 'h4200; i++)
         chk(mem.m[i], ref_m[i]);
   endtask

   // main sequence
   initial
   begin
      {ce_i, rst_i, sel_i} = 6'h3f;
      {cyc_i, stb_i, we_i, int_pending_i, adr_i, dat_i, dly, md} = '0;
      {fail_count, checked, xres, seed} = {64'h0, 8'h0, 32'h0000_d2db};
      vt = '{VAR_INC, VAR_INC_REP, VAR_DEC_REP, VAR_TEST_DEC};
      for (int i = 0; i < 65536; i++)
         mem.m[i] = (i >> 8 == 'h10) ? 8'(i & 'h7f) : 8'(rnd());
      mem.m['h4000] = 8'h00;
      mem.m['h4001] = 8'h40;
      mem.m['h4002] = 8'h80;
      ref_m = mem.m;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b1, 8'h24, 32'hffff_ffff);
      for (int a = 0; a < 40; a += 4)
      begin
         wb(1'b0, 8'(a), 32'h0);
         chk(q, 32'h0);
      end
      go(VAR_DEC_REP, 1'b1, 16'h4002, 16'h3, 1000);
      go(VAR_TEST_DEC, 1'b1, 16'h4000, 16'h2, 1000);
      for (int r = 0; r < 16; r++)
         go(vt[r % 4], 1'b1, 16'h4000 + 16'(rnd() & 'hff), 16'h1 + 16'(rnd() & 'h7), 1000);
      go(VAR_INC, 1'b1, 16'h4080, 16'h0, 1000);
      int_pending_i <= 1'b1;
      go(VAR_INC_REP, 1'b1, 16'h4010, 16'h4, 1);
      int_pending_i <= 1'b0;
      go(VAR_INC_REP, 1'b0, 16'h0, 16'h0, 1000);
      wb(1'b1, INSN_OFS, 32'hb800_0c90);
      wb(1'b1, CTRL_OFS, 32'h1);
      wb(1'b0, STATUS_OFS, 32'h0);
      chk(q, 32'h4);
      end_of_test();
   end

   // hang guard
   initial
   begin
      #500000;
      fail_count++;
      end_of_test();
   end
endmodule // byte_string_translate_unit_tb

bind byte_string_translate_unit translate_unit_properties props (.clk_i, .rst_i, .ce_i, .cyc_i,
   .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .mem_req_o, .mem_we_o, .mem_addr_o,
   .mem_wdata_o, .mem_rdata_i, .mem_ack_i, .int_pending_i, .busy_o, .done_o, .suspended_o);
